// ==== hw/lpai_top.sv ====
// device side of a low-power ddr memory: command decode, banks, bursts, power modes
// assumes a controller on the link clock and software on a plain register port
`timescale 1ns/100ps
module lpai_top #(
  parameter int DQ_W   = 16,
  parameter int ROW_W  = 4,
  parameter int COL_W  = 4,
  parameter int ADDR_W = 11
) (
  input  wire logic                  REF_CLK_IN,
  input  wire logic                  SRST_IN,
  input  wire logic                  TRUE_CLOCK_IN,
  input  wire logic                  COMPLEMENT_CLOCK_IN,
  input  wire logic                  CKE_IN,
  input  wire lpai_pkg::lpai_cmd_t   CMD_IN,
  input  wire logic [1:0]            BANK_IN,
  input  wire logic [ADDR_W-1:0]     ADDR_IN,
  input  wire logic [DQ_W-1:0]       DQ_IN,
  output logic      [DQ_W-1:0]       DQ_OUT,
  output logic                       DQ_OE_OUT,
  input  wire logic [DQ_W/8-1:0]     DQS_IN,
  output logic      [DQ_W/8-1:0]     DQS_OUT,
  output logic                       DQS_OE_OUT,
  input  wire logic [DQ_W/8-1:0]     WRITE_BYTE_MASK_IN,
  input  wire logic [1:0]            TEMP_SENSOR_IN,
  input  wire logic [3:0]            REG_ADDR_IN,
  input  wire logic [31:0]           REG_WDATA_IN,
  input  wire logic                  REG_WR_IN,
  input  wire logic                  REG_RD_IN,
  output logic      [31:0]           REG_RDATA_OUT
);
  localparam int LANES = DQ_W / 8;
  localparam int RW    = lpai_pkg::BANK_W + ROW_W;
  localparam int AW    = RW + COL_W;
  localparam int DEPTH = 1 << AW;
  localparam int BANKS = 1 << lpai_pkg::BANK_W;

  function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] s, input logic [4:0] i,
                                                 input logic [4:0] bl, input logic ilv);
    logic [COL_W-1:0] m;
    logic [COL_W-1:0] o;
    m = COL_W'(bl - 5'h01);
    o = ilv ? (s ^ COL_W'(i)) : (s + COL_W'(i));
    return (s & ~m) | (o & m);
  endfunction : burst_col

  // link domain ------------------------------------------------------------
  logic                  lrst_m_q;
  logic                  lrst_q;
  lpai_pkg::lpai_cmd_t   cmd_q;
  logic [1:0]            ba_q;
  logic [ADDR_W-1:0]     a_q;
  logic                  cke_q;
  logic                  cke_p_q;
  logic                  cclk_q;
  lpai_pkg::lpai_kind_t  kind;
  logic                  exec;
  lpai_pkg::lpai_pwr_t   pwr_q;
  logic [2:0]            bl_code_q;
  logic                  ilv_q;
  logic [2:0]            cl_q;
  logic [2:0]            part_arr_q;
  logic [BANKS-1:0]      open_q;
  logic [ROW_W-1:0]      row_q [BANKS];
  lpai_pkg::lpai_bst_t   bst_q;
  logic [1:0]            bbank_q;
  logic [ROW_W-1:0]      brow_q;
  logic [COL_W-1:0]      bcol_q;
  logic [4:0]            bidx_q;
  logic [4:0]            bbl_q;
  logic                  bilv_q;
  logic                  bap_q;
  logic [2:0]            bwait_q;
  logic                  burst_last;
  logic                  term;
  logic                  burst_end;
  logic                  start_ok;
  logic [AW-1:0]         ra0;
  logic [AW-1:0]         ra1;
  logic [DQ_W-1:0]       mem [DEPTH];
  logic [DEPTH-1:0]      valid_q;
  logic [DQ_W-1:0]       dout_rise_q;
  logic [DQ_W-1:0]       dout_fall_q;
  logic [DQ_W-1:0]       dout_fall_nq;
  logic                  rd_on_q;
  logic [DQ_W-1:0]       wlo;
  logic [DQ_W-1:0]       whi;
  logic [LANES-1:0]      mlo;
  logic [LANES-1:0]      mhi;
  logic                  lost_q;
  logic                  clk_err_q;
  logic                  aref_tgl_q;
  logic                  deep_entry;

  always_ff @(posedge TRUE_CLOCK_IN) begin
    lrst_m_q <= SRST_IN;
    lrst_q   <= lrst_m_q;
  end

  always_ff @(posedge TRUE_CLOCK_IN) begin
    cmd_q   <= CMD_IN; // R05
    ba_q    <= BANK_IN;
    a_q     <= ADDR_IN;
    cke_q   <= CKE_IN;
    cke_p_q <= cke_q;
    cclk_q  <= COMPLEMENT_CLOCK_IN;
  end

  assign kind       = lpai_pkg::lpai_kind(cmd_q);
  assign exec       = (pwr_q == lpai_pkg::PWR_ACTIVE) && cke_q && cke_p_q;
  assign deep_entry = (pwr_q == lpai_pkg::PWR_ACTIVE) && cke_p_q && !cke_q && (kind == lpai_pkg::K_TERM);

  // entry is taken from the command seen with cke dropping
  always_ff @(posedge TRUE_CLOCK_IN) begin
    if (lrst_q) begin
      pwr_q <= lpai_pkg::PWR_ACTIVE;
    end else begin
      unique case (pwr_q)
        lpai_pkg::PWR_ACTIVE: begin
          if (cke_p_q && !cke_q) begin
            if (kind == lpai_pkg::K_REF) begin
              pwr_q <= lpai_pkg::PWR_SREF;
            end else if (kind == lpai_pkg::K_TERM) begin
              pwr_q <= lpai_pkg::PWR_DEEP; // R14
            end else begin
              pwr_q <= lpai_pkg::PWR_DOWN; // R13
            end
          end
        end
        lpai_pkg::PWR_DOWN, lpai_pkg::PWR_SREF, lpai_pkg::PWR_DEEP: begin
          if (cke_q) begin
            pwr_q <= lpai_pkg::PWR_ACTIVE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge TRUE_CLOCK_IN) begin
    if (lrst_q) begin
      bl_code_q <= lpai_pkg::BL_RST;
      ilv_q     <= 1'b0;
      cl_q      <= lpai_pkg::CL_RST;
      part_arr_q <= lpai_pkg::PART_ARR_RST;
    end else if (exec && kind == lpai_pkg::K_LMR) begin
      if (ba_q == lpai_pkg::LMR_MODE) begin
        bl_code_q <= a_q[2:0]; // R10
        ilv_q     <= a_q[3];
        cl_q      <= (a_q[6:4] == 3'h2) ? 3'h2 : 3'h3;
      end else if (ba_q == lpai_pkg::LMR_EXT) begin
        part_arr_q <= a_q[2:0]; // R16
      end
    end
  end

  assign burst_last = (bidx_q + 5'h02) == bbl_q;
  assign term       = exec && kind == lpai_pkg::K_TERM && !bap_q &&
                      (bst_q == lpai_pkg::BST_READ || bst_q == lpai_pkg::BST_RWAIT);
  assign burst_end  = ((bst_q == lpai_pkg::BST_READ || bst_q == lpai_pkg::BST_WRITE) && burst_last) || term;
  assign start_ok   = exec && bst_q == lpai_pkg::BST_IDLE && open_q[ba_q] &&
                      (kind == lpai_pkg::K_READ || kind == lpai_pkg::K_WRITE); // R08

  // other banks keep accepting activate and precharge during a burst
  always_ff @(posedge TRUE_CLOCK_IN) begin
    if (lrst_q) begin
      open_q <= '0;
      for (int b = 0; b < BANKS; b++) begin
        row_q[b] <= '0;
      end
    end else begin
      if (burst_end && bap_q) begin
        open_q[bbank_q] <= 1'b0; // R11
      end
      if (exec && kind == lpai_pkg::K_ACT) begin
        open_q[ba_q] <= 1'b1; // R08 R12
        row_q[ba_q]  <= a_q[ROW_W-1:0];
      end else if (exec && kind == lpai_pkg::K_PRE) begin
        if (a_q[lpai_pkg::PREC_BIT]) begin
          open_q <= '0;
        end else begin
          open_q[ba_q] <= 1'b0; // R12
        end
      end
    end
  end

  always_ff @(posedge TRUE_CLOCK_IN) begin
    if (lrst_q) begin
      bst_q   <= lpai_pkg::BST_IDLE;
      bbank_q <= '0;
      brow_q  <= '0;
      bcol_q  <= '0;
      bidx_q  <= '0;
      bbl_q   <= 5'h04;
      bilv_q  <= 1'b0;
      bap_q   <= 1'b0;
      bwait_q <= '0;
    end else if (start_ok) begin
      bbank_q <= ba_q;
      brow_q  <= row_q[ba_q];
      bcol_q  <= a_q[COL_W-1:0]; // R09
      bidx_q  <= '0;
      bbl_q   <= lpai_pkg::lpai_bl(bl_code_q); // R10
      bilv_q  <= ilv_q;
      bap_q   <= a_q[lpai_pkg::PREC_BIT]; // R18
      bwait_q <= cl_q - 3'h2;
      if (kind == lpai_pkg::K_WRITE) begin
        bst_q <= lpai_pkg::BST_WRITE;
      end else begin
        bst_q <= (cl_q == 3'h2) ? lpai_pkg::BST_READ : lpai_pkg::BST_RWAIT;
      end
    end else if (burst_end) begin
      bst_q <= lpai_pkg::BST_IDLE;
    end else if (bst_q == lpai_pkg::BST_RWAIT) begin
      bwait_q <= bwait_q - 3'h1;
      if (bwait_q == 3'h1) begin
        bst_q <= lpai_pkg::BST_READ;
      end
    end else if (bst_q != lpai_pkg::BST_IDLE) begin
      bidx_q <= bidx_q + 5'h02; // R07
    end
  end

  assign ra0 = {bbank_q, brow_q, burst_col(bcol_q, bidx_q, bbl_q, bilv_q)}; // R07
  assign ra1 = {bbank_q, brow_q, burst_col(bcol_q, bidx_q + 5'h01, bbl_q, bilv_q)};

  // strobe-clocked capture per lane; pair is stable from mid-cycle to the next
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [7:0] rise_q;
    logic [7:0] lo_q;
    logic [7:0] hi_q;
    logic       mr_q;
    logic       mlo_q;
    logic       mhi_q;
    always_ff @(posedge DQS_IN[l]) begin
      rise_q <= DQ_IN[l*8 +: 8]; // R06 R04
      mr_q   <= WRITE_BYTE_MASK_IN[l];
    end
    always_ff @(negedge DQS_IN[l]) begin
      lo_q  <= rise_q; // R06 R03
      mlo_q <= mr_q;
      hi_q  <= DQ_IN[l*8 +: 8];
      mhi_q <= WRITE_BYTE_MASK_IN[l];
    end
    assign wlo[l*8 +: 8] = lo_q;
    assign whi[l*8 +: 8] = hi_q;
    assign mlo[l]        = mlo_q;
    assign mhi[l]        = mhi_q;
  end

  always_ff @(posedge TRUE_CLOCK_IN) begin
    if (lrst_q || deep_entry) begin
      valid_q <= '0; // R14
    end else if (bst_q == lpai_pkg::BST_WRITE) begin
      valid_q[ra0] <= 1'b1;
      valid_q[ra1] <= 1'b1;
    end
  end

  always_ff @(posedge TRUE_CLOCK_IN) begin
    if (!lrst_q && bst_q == lpai_pkg::BST_WRITE) begin
      for (int l = 0; l < LANES; l++) begin
        if (!mlo[l] || !valid_q[ra0]) begin
          mem[ra0][l*8 +: 8] <= mlo[l] ? 8'h00 : wlo[l*8 +: 8]; // R19 R01
        end
        if (!mhi[l] || !valid_q[ra1]) begin
          mem[ra1][l*8 +: 8] <= mhi[l] ? 8'h00 : whi[l*8 +: 8]; // R19
        end
      end
    end
  end

  always_ff @(posedge TRUE_CLOCK_IN) begin
    if (lrst_q) begin
      dout_rise_q <= '0;
      dout_fall_q <= '0;
      rd_on_q     <= 1'b0;
    end else begin
      rd_on_q <= (bst_q == lpai_pkg::BST_READ) && !term; // R02
      if (bst_q == lpai_pkg::BST_READ) begin
        dout_rise_q <= valid_q[ra0] ? mem[ra0] : '0; // R01 R14
        dout_fall_q <= valid_q[ra1] ? mem[ra1] : '0;
      end
    end
  end

  always_ff @(negedge TRUE_CLOCK_IN) begin
    if (lrst_q) begin
      dout_fall_nq <= '0;
    end else begin
      dout_fall_nq <= dout_fall_q; // R06
    end
  end

  // no lock loop: the clock itself selects the half, so outputs track it directly
  assign DQ_OUT     = TRUE_CLOCK_IN ? dout_rise_q : dout_fall_nq; // R17 R01
  assign DQS_OUT    = {LANES{rd_on_q & TRUE_CLOCK_IN}}; // R03 R04
  assign DQ_OE_OUT  = rd_on_q;
  assign DQS_OE_OUT = rd_on_q; // R02

  always_ff @(posedge TRUE_CLOCK_IN) begin
    if (lrst_q) begin
      lost_q     <= 1'b0;
      clk_err_q  <= 1'b0;
      aref_tgl_q <= 1'b0;
    end else begin
      lost_q   <= lost_q | deep_entry;
      clk_err_q <= clk_err_q | cclk_q; // R05
      if (exec && kind == lpai_pkg::K_REF && open_q == '0) begin
        aref_tgl_q <= ~aref_tgl_q; // R13
      end
    end
  end

  // register domain --------------------------------------------------------
  lpai_pkg::lpai_stat_t  stat_l;
  lpai_pkg::lpai_stat_t  stat_m_q;
  lpai_pkg::lpai_stat_t  stat_s_q;
  logic                  tgl_m_q;
  logic                  tgl_s_q;
  logic                  tgl_p_q;
  logic [1:0]            temp_m_q;
  logic [1:0]            temp_s_q;
  logic [15:0]           base_q;
  logic [15:0]           timer_q;
  logic [15:0]           sref_cnt_q;
  logic [15:0]           aref_cnt_q;
  logic [RW-1:0]         rrow_q;
  logic [RW-1:0]         cover_last;
  logic                  in_sref;

  assign stat_l = '{lost: lost_q, clk_err: clk_err_q, part_arr: part_arr_q, open: open_q, pwr: pwr_q};

  // status bits are slow levels; a skew of one cycle between bits is harmless
  always_ff @(posedge REF_CLK_IN) begin
    stat_m_q <= stat_l;
    stat_s_q <= stat_m_q;
    tgl_m_q  <= aref_tgl_q;
    tgl_s_q  <= tgl_m_q;
    tgl_p_q  <= tgl_s_q;
    temp_m_q <= TEMP_SENSOR_IN;
    temp_s_q <= temp_m_q;
  end

  assign in_sref    = stat_s_q.pwr == lpai_pkg::PWR_SREF;
  assign cover_last = RW'(({1'b0, {RW{1'b1}}} + 1'b1) >> lpai_pkg::lpai_part_arr_shift(stat_s_q.part_arr)) - 1'b1;

  // self refresh keeps time here, as the link clock may stop
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      timer_q    <= lpai_pkg::SREF_BASE_RST;
      rrow_q     <= '0;
      sref_cnt_q <= '0;
    end else if (!in_sref) begin
      timer_q <= base_q >> temp_s_q; // R15
    end else if (timer_q <= 16'h0001) begin
      timer_q    <= base_q >> temp_s_q; // R15
      rrow_q     <= (rrow_q >= cover_last) ? '0 : rrow_q + 1'b1; // R16
      sref_cnt_q <= sref_cnt_q + 16'h0001;
    end else begin
      timer_q <= timer_q - 16'h0001;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      aref_cnt_q <= '0;
    end else if (tgl_s_q ^ tgl_p_q) begin
      aref_cnt_q <= aref_cnt_q + 16'h0001; // R13
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      base_q <= lpai_pkg::SREF_BASE_RST;
    end else if (REG_WR_IN && REG_ADDR_IN == lpai_pkg::REG_SREF_BASE) begin
      base_q <= REG_WDATA_IN[15:0];
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN || !REG_RD_IN) begin
      REG_RDATA_OUT <= '0;
    end else begin
      unique case (REG_ADDR_IN)
        lpai_pkg::REG_STATUS: REG_RDATA_OUT <= {10'h000, RW'(rrow_q), 3'h0, temp_s_q,
                                                 stat_s_q};
        lpai_pkg::REG_SREF_BASE: REG_RDATA_OUT <= {16'h0000, base_q};
        lpai_pkg::REG_SREF_COUNT: REG_RDATA_OUT <= {16'h0000, sref_cnt_q};
        lpai_pkg::REG_AREF_COUNT: REG_RDATA_OUT <= {16'h0000, aref_cnt_q};
        default: REG_RDATA_OUT <= '0;
      endcase
    end
  end
endmodule : lpai_top

// ==== common/lpai_pkg.sv ====
// constants, types and helpers for the low-power ddr access interface
// assumes one link clock domain at the pins and one register clock domain
// How it works
// R01 - one double-width core word per cycle leaves the pins as two half-cycle words
// R02 - device drives the byte strobe on reads; controller drives it on writes
// R03 - read strobe edges align with data; write strobes sit mid data eye
// R04 - every byte lane has its own strobe, two for x16, four for x32
// R05 - commands and address sampled on each rising true clock edge
// R06 - write data taken on both strobe edges; read data on both edges
// R07 - bursts start at the chosen column, run programmed length and ordering
// R08 - activate opens bank and row before any column access
// R09 - address with read or write gives the burst start column
// R10 - burst length programmable to two, four, eight or sixteen
// R11 - auto precharge closes the row by itself when the burst ends
// R12 - banks work concurrently; activate or precharge overlaps other bursts
// R13 - auto refresh and power-down modes exist beside normal operation
// R14 - deep power-down drops array contents; data reads invalid afterwards
// R15 - self refresh rate follows the internal temperature sensor on its own
// R16 - self refresh covers only the array part picked in extended mode
// R17 - no delay-locked loop; outputs follow the clock with no lock wait
// R18 - address bit ten high with a column access requests auto precharge
// R19 - byte mask high blocks that byte of write data, low writes it
package lpai_pkg;
  localparam int BANK_W = 2;
  localparam int PREC_BIT = 10;
  localparam logic [1:0] LMR_MODE = 2'h0;
  localparam logic [1:0] LMR_EXT = 2'h2;
  localparam logic [2:0] BL_RST = 3'h2;
  localparam logic [2:0] CL_RST = 3'h3;
  localparam logic [2:0] PART_ARR_RST = 3'h0;
  localparam logic [15:0] SREF_BASE_RST = 16'h0100;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_SREF_BASE = 4'h4;
  localparam logic [3:0] REG_SREF_COUNT = 4'h8;
  localparam logic [3:0] REG_AREF_COUNT = 4'hc;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } lpai_cmd_t;

  typedef enum logic [1:0] {PWR_ACTIVE, PWR_DOWN, PWR_SREF, PWR_DEEP} lpai_pwr_t;
  typedef enum logic [1:0] {BST_IDLE, BST_RWAIT, BST_READ, BST_WRITE} lpai_bst_t;
  typedef enum logic [2:0] {K_NOP, K_ACT, K_READ, K_WRITE, K_TERM, K_PRE, K_REF, K_LMR} lpai_kind_t;

  typedef struct packed {
    logic lost;
    logic clk_err;
    logic [2:0] part_arr;
    logic [3:0] open;
    lpai_pwr_t pwr;
  } lpai_stat_t;

  function automatic lpai_kind_t lpai_kind(input lpai_cmd_t c);
    if (c.cs_n) begin
      return K_NOP;
    end
    unique case ({c.ras_n, c.cas_n, c.we_n})
      3'h7: return K_NOP;
      3'h3: return K_ACT;
      3'h5: return K_READ;
      3'h4: return K_WRITE;
      3'h6: return K_TERM;
      3'h2: return K_PRE;
      3'h1: return K_REF;
      3'h0: return K_LMR;
    endcase
  endfunction : lpai_kind

  function automatic logic [4:0] lpai_bl(input logic [2:0] code);
    unique case (code)
      3'h1: return 5'h02;
      3'h2: return 5'h04;
      3'h3: return 5'h08;
      3'h4: return 5'h10;
      default: return 5'h04;
    endcase
  endfunction : lpai_bl

  function automatic logic [2:0] lpai_part_arr_shift(input logic [2:0] p);
    unique case (p)
      3'h1: return 3'h1;
      3'h2: return 3'h2;
      3'h5: return 3'h3;
      3'h6: return 3'h4;
      default: return 3'h0;
    endcase
  endfunction : lpai_part_arr_shift
endpackage : lpai_pkg

// ==== testbench/lpai_top_checker.sv ====
// port assertions for the ddr access block, register and link domains
// assumes a bind into lpai_top; link properties run on the true clock
`timescale 1ns/100ps
module lpai_top_checker #(
  parameter int DQ_W = 16
) (
  input wire logic                REF_CLK_IN,
  input wire logic                SRST_IN,
  input wire logic                TRUE_CLOCK_IN,
  input wire logic                CKE_IN,
  input wire lpai_pkg::lpai_cmd_t CMD_IN,
  input wire logic                DQ_OE_OUT,
  input wire logic [DQ_W/8-1:0]   DQS_OUT,
  input wire logic                DQS_OE_OUT,
  input wire logic                REG_RD_IN,
  input wire logic [31:0]         REG_RDATA_OUT
);
  logic rd_take;
  logic wr_take;
  // previous-edge cke ignored: a looser cause only widens the window
  assign rd_take = CKE_IN && !CMD_IN.cs_n && CMD_IN.ras_n && !CMD_IN.cas_n && CMD_IN.we_n;
  assign wr_take = CKE_IN && !CMD_IN.cs_n && CMD_IN.ras_n && !CMD_IN.cas_n && !CMD_IN.we_n;
  sequence s_rd_recent;
    $past(rd_take, 2) || $past(rd_take, 3) || $past(rd_take, 4) || $past(rd_take, 5);
  endsequence
  sequence s_wr_clean;
    wr_take && !DQ_OE_OUT && !$past(rd_take) && !$past(rd_take, 2) && !$past(rd_take, 3);
  endsequence
  property p_oe_cause;
    @(posedge TRUE_CLOCK_IN) disable iff (SRST_IN) $rose(DQ_OE_OUT) |-> s_rd_recent;
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("read data without read");
  property p_oe_bound;
    @(posedge TRUE_CLOCK_IN) disable iff (SRST_IN) $rose(DQ_OE_OUT) |-> ##[1:8] !DQ_OE_OUT;
  endproperty
  a_oe_bound: assert property (p_oe_bound) else $error("read burst too long");
  property p_wr_quiet;
    @(posedge TRUE_CLOCK_IN) disable iff (SRST_IN) s_wr_clean |-> !DQ_OE_OUT [*3];
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("device drives during write");
  property p_strobe_oe;
    @(posedge TRUE_CLOCK_IN) disable iff (SRST_IN) DQS_OE_OUT == DQ_OE_OUT;
  endproperty
  a_strobe_oe: assert property (p_strobe_oe) else $error("strobe enable differs from data enable");
  property p_strobe_phase;
    @(negedge TRUE_CLOCK_IN) disable iff (SRST_IN) DQS_OUT == {(DQ_W/8){DQS_OE_OUT}};
  endproperty
  a_strobe_phase: assert property (p_strobe_phase) else $error("strobe high phase wrong");
  property p_strobe_low;
    @(posedge TRUE_CLOCK_IN) disable iff (SRST_IN) DQS_OUT == '0;
  endproperty
  a_strobe_low: assert property (p_strobe_low) else $error("strobe high in low phase");
  property p_cke_hold;
    @(posedge TRUE_CLOCK_IN) disable iff (SRST_IN) !CKE_IN [*5] |-> !$rose(DQ_OE_OUT);
  endproperty
  a_cke_hold: assert property (p_cke_hold) else $error("burst started in power save");
  property p_rdata_idle;
    @(posedge REF_CLK_IN) disable iff (SRST_IN) !$past(REG_RD_IN) |-> REG_RDATA_OUT == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
endmodule : lpai_top_checker
bind lpai_top lpai_top_checker #(.DQ_W(DQ_W)) u_chk (
  .REF_CLK_IN(REF_CLK_IN), .SRST_IN(SRST_IN), .TRUE_CLOCK_IN(TRUE_CLOCK_IN), .CKE_IN(CKE_IN),
  .CMD_IN(CMD_IN), .DQ_OE_OUT(DQ_OE_OUT), .DQS_OUT(DQS_OUT), .DQS_OE_OUT(DQS_OE_OUT),
  .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT));

// ==== testbench/lpai_ctrl_model.sv ====
// memory controller model: link clock, commands, write bursts, read capture
// assumes x16 device; the bench calls op, wr and rd in sequence
`timescale 1ns/100ps
module lpai_ctrl_model (
  output logic                tck_out,
  output logic                tckn_out,
  output logic                cke_out,
  output lpai_pkg::lpai_cmd_t cmd_out,
  output logic [1:0]          bank_out,
  output logic [10:0]         addr_out,
  output logic [15:0]         dq_out,
  output logic [1:0]          dqs_out,
  output logic [1:0]          mask_out,
  input  wire logic [15:0]    rd_dq_in,
  input  wire logic           rd_oe_in,
  input  wire logic [1:0]     rd_dqs_in
);
  logic [15:0] got [$];
  logic        dqs_bad;
  initial begin
    tck_out = 1'b0;
    tckn_out = 1'b1;
    cke_out = 1'b1;
    cmd_out = 4'hf;
    bank_out = 2'h0;
    addr_out = 11'h0;
    dq_out = 16'h0;
    dqs_out = 2'h0;
    mask_out = 2'h0;
    dqs_bad = 1'b0;
  end
  // clock runs free; refresh and lock-free timing need no stop
  // complement falls first in the same step, so the device never samples it mid-race
  always #7.5 begin
    tckn_out = tck_out;
    tck_out  = ~tck_out;
  end
  task op(input logic [2:0] rcw, input logic [1:0] b, input logic [10:0] a, input logic k = 1'b1);
    @(posedge tck_out);
    cmd_out <= {1'b0, rcw};
    bank_out <= b;
    addr_out <= a;
    cke_out <= k;
    @(posedge tck_out);
    cmd_out <= 4'hf;
    addr_out <= ~a;
  endtask : op
  // data settles a quarter cycle before each strobe edge: centred eye
  task wr(input logic [63:0] w, input logic [7:0] m);
    @(negedge tck_out);
    for (int i = 0; i < 5; i++) begin
      if (i > 0) begin
        @(tck_out);
        dqs_out = ~dqs_out;
      end
      #3.7;
      dq_out = (i < 4) ? w[16*i +: 16] : ~dq_out;
      mask_out = (i < 4) ? m[2*i +: 2] : ~mask_out;
    end
  endtask : wr
  task rd();
    got.delete();
    dqs_bad = 1'b0;
    repeat (10) begin
      @(posedge tck_out);
      #2;
      while (rd_oe_in === 1'b1) begin
        got.push_back(rd_dq_in);
        if (rd_dqs_in !== 2'h3) dqs_bad = 1'b1;
        @(negedge tck_out);
        #2;
        got.push_back(rd_dq_in);
        if (rd_dqs_in !== 2'h0) dqs_bad = 1'b1;
        @(posedge tck_out);
        #2;
      end
    end
  endtask : rd
endmodule : lpai_ctrl_model

// ==== testbench/test_lpddr_access_interface.sv ====
// bench for the ddr access block: registers, bursts, masks, power modes
// assumes the controller model makes the link clock; checker bound to uut
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin n_fail++; $display("Error %s expected %0h seen %0h", nm, ex, gt); end end
module test_lpddr_access_interface;
  logic                clk = 1'b0;
  logic                srst = 1'b1;
  logic [3:0]          ra = 4'h0;
  logic [31:0]         rw = 32'h0;
  logic                wr = 1'b0;
  logic                rd = 1'b0;
  logic [1:0]          temp = 2'h1;
  logic                tck, tckn, cke, oe, dqs_oe;
  lpai_pkg::lpai_cmd_t cmd;
  logic [1:0]          bank, dqs, mask, dqs_o;
  logic [10:0]         addr;
  logic [15:0]         dq, dq_o;
  logic [31:0]         rdata;
  int                  n_fail = 0;
  int                  comparisons = 0;
  int                  cycles = 0;
  lpai_ctrl_model u_ctrl (.tck_out(tck), .tckn_out(tckn), .cke_out(cke), .cmd_out(cmd), .bank_out(bank),
    .addr_out(addr), .dq_out(dq), .dqs_out(dqs), .mask_out(mask), .rd_dq_in(dq_o), .rd_oe_in(oe),
    .rd_dqs_in(dqs_o));
  lpai_top uut (.REF_CLK_IN(clk), .SRST_IN(srst), .TRUE_CLOCK_IN(tck), .COMPLEMENT_CLOCK_IN(tckn),
    .CKE_IN(cke), .CMD_IN(cmd), .BANK_IN(bank), .ADDR_IN(addr), .DQ_IN(dq), .DQ_OUT(dq_o), .DQ_OE_OUT(oe),
    .DQS_IN(dqs), .DQS_OUT(dqs_o), .DQS_OE_OUT(dqs_oe), .WRITE_BYTE_MASK_IN(mask), .TEMP_SENSOR_IN(temp),
    .REG_ADDR_IN(ra), .REG_WDATA_IN(rw), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata));
  always #20 clk = ~clk;
  task reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    rw <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : reg_rd
  task stop_test();
    $display("comparisons %0d errors %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    logic [31:0] d;
    logic [31:0] e;
    logic [15:0] exp_rd [4];
    exp_rd = '{16'h0022, 16'h1111, 16'h4444, 16'h3333};
    // link reset passes two flops: hold long enough for both domains
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    reg_rd(4'h4, d);
    `CHK("sref base reset", 32'h100, d)
    reg_wr(4'h4, 32'h4);
    reg_wr(4'h0, 32'hffffffff);
    reg_rd(4'h4, d);
    `CHK("sref base", 32'h4, d)
    reg_rd(4'h2, d);
    `CHK("unmapped", 32'h0, d)
    reg_rd(4'h0, d);
    `CHK("status", 32'h800, d & 32'h1fff)
    u_ctrl.op(3'h0, 2'h2, 11'h005);
    repeat (4) @(posedge clk);
    reg_rd(4'h0, d);
    `CHK("partial array", 3'h5, d[8:6])
    for (int c = 1; c < 5; c++) begin
      u_ctrl.op(3'h0, 2'h0, {4'h0, 3'h2, 1'b0, 3'(c)});
      u_ctrl.op(3'h3, 2'h3, 11'h000);
      u_ctrl.op(3'h5, 2'h3, 11'h400);
      u_ctrl.rd();
      `CHK("burst words", 1 << c, u_ctrl.got.size())
    end
    u_ctrl.op(3'h0, 2'h0, 11'h03a);
    u_ctrl.op(3'h3, 2'h1, 11'h003);
    u_ctrl.op(3'h4, 2'h1, 11'h004);
    u_ctrl.wr(64'h4444_3333_2222_1111, 8'h08);
    u_ctrl.op(3'h5, 2'h1, 11'h405);
    u_ctrl.op(3'h3, 2'h2, 11'h001);
    u_ctrl.rd();
    `CHK("read words", 4, u_ctrl.got.size())
    for (int i = 0; i < 4; i++) `CHK("read data", exp_rd[i], u_ctrl.got[i])
    `CHK("strobe", 1'b0, u_ctrl.dqs_bad)
    repeat (4) @(posedge clk);
    reg_rd(4'h0, d);
    `CHK("open banks", 4'h4, d[5:2])
    u_ctrl.op(3'h5, 2'h1, 11'h004);
    u_ctrl.rd();
    `CHK("closed bank read", 0, u_ctrl.got.size())
    u_ctrl.op(3'h2, 2'h0, 11'h400);
    u_ctrl.op(3'h1, 2'h0, 11'h000);
    repeat (6) @(posedge clk);
    reg_rd(4'hc, d);
    `CHK("auto refresh", 32'h1, d)
    u_ctrl.op(3'h1, 2'h0, 11'h000, 1'b0);
    for (int t = 0; t < 2; t++) begin
      temp <= 2'(t);
      repeat (8) @(posedge clk);
      reg_rd(4'h8, d);
      repeat (40) @(posedge clk);
      reg_rd(4'h8, e);
      `CHK("sref rate", 1'b1, (e - d >= (32'h8 << t)) && (e - d <= (32'hc << t)))
    end
    reg_rd(4'h0, d);
    `CHK("self refresh", 2'h2, d[1:0])
    u_ctrl.op(3'h7, 2'h0, 11'h000);
    u_ctrl.op(3'h6, 2'h0, 11'h000, 1'b0);
    repeat (6) @(posedge clk);
    reg_rd(4'h0, d);
    `CHK("deep power down", 3'h7, {d[10], d[1:0]})
    u_ctrl.op(3'h7, 2'h0, 11'h000);
    u_ctrl.op(3'h3, 2'h1, 11'h003);
    u_ctrl.op(3'h5, 2'h1, 11'h004);
    u_ctrl.rd();
    `CHK("lost data", 16'h0, u_ctrl.got[0])
    repeat (4) @(posedge clk);
    reg_rd(4'h0, d);
    `CHK("row kept open", 4'h2, d[5:2])
    stop_test();
  end
endmodule : test_lpddr_access_interface
